// *** ecaas_regs.svh ***
// Offsets, field positions, reset values and fixed codes of the config access slice
`ifndef ECAAS_REGS_SVH
`define ECAAS_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ECAAS_PTR_OFS 12'h0f8
`define ECAAS_WIN_OFS 12'h0fc
`define ECAAS_CAP_OFS 12'h100
`define ECAAS_FLAGS_OFS 12'h104

// ----------------------------------------
// Pointer fields
// ----------------------------------------
`define ECAAS_PTR_REG_LSB 2
`define ECAAS_PTR_REG_MSB 7
`define ECAAS_PTR_EXT_LSB 8
`define ECAAS_PTR_EXT_MSB 11
`define ECAAS_PTR_RST 32'h0000_0000

// ----------------------------------------
// Capability header fields
// ----------------------------------------
`define ECAAS_CAP_CODE 16'h0001
`define ECAAS_CAP_VER 4'h1
`define ECAAS_CHAIN_LINK 12'h200

// ----------------------------------------
// Uncorrectable flag bit positions
// ----------------------------------------
`define ECAAS_BIT_LINK_PROTO 4
`define ECAAS_BIT_LINK_LOSS 5
`define ECAAS_BIT_POISONED 12
`define ECAAS_BIT_CREDIT 13
`define ECAAS_BIT_REPLY_TO 14
`define ECAAS_BIT_RESP_ABORT 15
`define ECAAS_BIT_STRAY 16
`define ECAAS_BIT_RX_OVF 17
`define ECAAS_BIT_MALFORMED 18
`define ECAAS_BIT_ECRC 19
`define ECAAS_BIT_UNSUP 20
`define ECAAS_FLAGS_WMASK 32'h001f_3030
`define ECAAS_FLAGS_RST 32'h0000_0000

`endif

// *** ecaas_pkg.sv ***
// Types shared by the config access slice
package ecaas_pkg;

  typedef struct packed {
    logic valid;
    logic wr;
    logic smbus;
    logic [11:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } ecaas_req_s;

  typedef struct packed {
    logic ack;
    logic hit;
    logic [31:0] rdata;
  } ecaas_rsp_s;

  typedef struct packed {
    logic valid;
    logic wr;
    logic [9:0] idx;
    logic [3:0] be;
    logic [31:0] wdata;
  } ecaas_fwd_s;

  typedef struct packed {
    logic link_protocol_fault;
    logic sudden_link_loss;
    logic poisoned;
    logic credit_protocol_fault;
    logic stray_reply;
    logic rx_overflow;
    logic malformed;
    logic ecrc;
    logic unsupported;
  } ecaas_evt_s;

  typedef enum logic {
    ECAAS_IDLE = 1'b0,
    ECAAS_FWD = 1'b1
  } ecaas_phase_e;

endpackage

// *** ecaas_err_flags.sv ***
// Sticky uncorrectable error flag register
`timescale 1ns/1ps
`default_nettype none
`include "ecaas_regs.svh"

module ecaas_err_flags
(
  input wire logic core_clk,
  input wire logic rst,
  input wire ecaas_pkg::ecaas_evt_s evt,
  input wire logic clr_valid,
  input wire logic [31:0] clr_mask,
  output logic [31:0] flags
);
  import ecaas_pkg::*;

  typedef struct packed {
    logic [31:0] flags;
  } ecaas_flag_state_s;

  ecaas_flag_state_s st;
  ecaas_flag_state_s next_st;
  logic [31:0] set_vec;

  // ----------------------------------------
  // Event mapping
  // ----------------------------------------
  always_comb
  begin
    set_vec = '0;
    set_vec[`ECAAS_BIT_LINK_PROTO] = evt.link_protocol_fault;
    set_vec[`ECAAS_BIT_LINK_LOSS] = evt.sudden_link_loss;
    set_vec[`ECAAS_BIT_POISONED] = evt.poisoned;
    set_vec[`ECAAS_BIT_CREDIT] = evt.credit_protocol_fault;
    set_vec[`ECAAS_BIT_STRAY] = evt.stray_reply;
    set_vec[`ECAAS_BIT_RX_OVF] = evt.rx_overflow;
    set_vec[`ECAAS_BIT_MALFORMED] = evt.malformed;
    set_vec[`ECAAS_BIT_ECRC] = evt.ecrc;
    set_vec[`ECAAS_BIT_UNSUP] = evt.unsupported;
  end

  // ----------------------------------------
  // Update
  // ----------------------------------------
  // Set beats clear so an event landing on a clear is never lost
  always_comb
  begin
    next_st = st;
    for (int i = 0; i < 32; i++)
    begin
      if (set_vec[i])
        next_st.flags[i] = 1'b1;
      else if (clr_valid && clr_mask[i])
        next_st.flags[i] = 1'b0;
    end
    // Reply timeout, responder abort and reserved bits never hold a one
    next_st.flags = next_st.flags & `ECAAS_FLAGS_WMASK;
  end

  // Only the fundamental reset reaches these flops; hot reset does not
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      st.flags <= `ECAAS_FLAGS_RST;
    else
      st <= next_st;
  end

  assign flags = st.flags;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_flag_set_wins: assert property ((set_vec != 32'h0) |=> ((flags & $past(set_vec)) == $past(set_vec)))
    else $error("Error event did not set its flag");
  a_flag_hard_zero: assert property ((flags & ~`ECAAS_FLAGS_WMASK) == 32'h0)
    else $error("Hardwired or reserved flag bit is set");
  a_flag_w1c_clear: assert property ((clr_valid && (set_vec == 32'h0)) |=> ((flags & $past(clr_mask)) == 32'h0))
    else $error("Write of one did not clear flag");
  a_flag_hold_idle: assert property ((!clr_valid && (set_vec == 32'h0)) |=> $stable(flags))
    else $error("Flag changed without event or clear");
endmodule
`default_nettype wire

// *** ecaas_top.sv ***
// Extended config window, error capability header and uncorrectable flags of one port
`timescale 1ns/1ps
`default_nettype none
`include "ecaas_regs.svh"

module ecaas_top
#(
  parameter logic [11:0] CHAIN_LINK = `ECAAS_CHAIN_LINK
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic hot_reset,
  input wire ecaas_pkg::ecaas_req_s cfg_req,
  output ecaas_pkg::ecaas_rsp_s cfg_rsp,
  output logic cfg_busy,
  output ecaas_pkg::ecaas_fwd_s fwd_req,
  input wire ecaas_pkg::ecaas_rsp_s fwd_rsp,
  input wire ecaas_pkg::ecaas_evt_s evt,
  output logic [31:0] err_flags
);
  import ecaas_pkg::*;

  if (CHAIN_LINK[1:0] != 2'b00)
  begin : g_bad_link
    $error("CHAIN_LINK must be dword aligned");
  end

  typedef struct packed {
    ecaas_phase_e phase;
    logic [5:0] ptr_reg;
    logic [3:0] ptr_ext;
    ecaas_rsp_s rsp;
    ecaas_fwd_s fwd;
  } ecaas_state_s;

  localparam logic [9:0] IDX_PTR = 10'(`ECAAS_PTR_OFS >> 2);
  localparam logic [9:0] IDX_WIN = 10'(`ECAAS_WIN_OFS >> 2);
  localparam logic [9:0] IDX_CAP = 10'(`ECAAS_CAP_OFS >> 2);
  localparam logic [9:0] IDX_FLAGS = 10'(`ECAAS_FLAGS_OFS >> 2);

  ecaas_state_s st;
  ecaas_state_s next_st;
  logic [31:0] flags;
  logic take;
  logic win;
  logic [9:0] tgt;
  logic local_hit;
  logic [31:0] local_val;
  logic [31:0] merged;
  logic flag_clr_valid;
  logic [31:0] flag_clr_mask;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  function automatic logic is_local(input logic [9:0] idx);
    is_local = (idx == IDX_PTR) || (idx == IDX_CAP) || (idx == IDX_FLAGS);
  endfunction

  // ----------------------------------------
  // Sticky flags
  // ----------------------------------------
  ecaas_err_flags u_flags
  (
    .core_clk(core_clk),
    .rst(rst),
    .evt(evt),
    .clr_valid(flag_clr_valid),
    .clr_mask(flag_clr_mask),
    .flags(flags)
  );

  // ----------------------------------------
  // Target selection and local read value
  // ----------------------------------------
  always_comb
  begin
    take = cfg_req.valid && (st.phase == ECAAS_IDLE);
    win = (cfg_req.addr[11:2] == IDX_WIN);
    // Window accesses go where the pointer aims, others where they are addressed
    tgt = win ? {st.ptr_ext, st.ptr_reg} : cfg_req.addr[11:2];
    local_hit = is_local(tgt);
    local_val = 32'h0;
    case (tgt)
      IDX_PTR:
      begin
        local_val[`ECAAS_PTR_REG_MSB:`ECAAS_PTR_REG_LSB] = st.ptr_reg;
        local_val[`ECAAS_PTR_EXT_MSB:`ECAAS_PTR_EXT_LSB] = st.ptr_ext;
      end
      IDX_CAP:
        local_val = {CHAIN_LINK, `ECAAS_CAP_VER, `ECAAS_CAP_CODE};
      IDX_FLAGS:
        local_val = flags;
      default:
        local_val = 32'h0;
    endcase
    merged = (local_val & ~lane_mask(cfg_req.be)) | (cfg_req.wdata & lane_mask(cfg_req.be));
  end

  // ----------------------------------------
  // Access sequencing
  // ----------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.rsp.ack = 1'b0;
    next_st.fwd.valid = 1'b0;
    flag_clr_valid = 1'b0;
    flag_clr_mask = 32'h0;
    case (st.phase)
      ECAAS_IDLE:
      begin
        if (take)
        begin
          next_st.rsp.ack = 1'b1;
          next_st.rsp.hit = 1'b1;
          next_st.rsp.rdata = 32'h0;
          if (win && cfg_req.smbus)
          begin
            next_st.rsp.rdata = 32'h0;
          end
          else if (win && (tgt == IDX_WIN))
          begin
            next_st.rsp.rdata = 32'h0;
          end
          else if (local_hit)
          begin
            if (!cfg_req.wr)
              next_st.rsp.rdata = local_val & lane_mask(cfg_req.be);
            else if (tgt == IDX_PTR)
            begin
              next_st.ptr_reg = merged[`ECAAS_PTR_REG_MSB:`ECAAS_PTR_REG_LSB];
              next_st.ptr_ext = merged[`ECAAS_PTR_EXT_MSB:`ECAAS_PTR_EXT_LSB];
            end
            else if (tgt == IDX_FLAGS)
            begin
              flag_clr_valid = 1'b1;
              flag_clr_mask = cfg_req.wdata & lane_mask(cfg_req.be);
            end
          end
          else if (win)
          begin
            // Registers outside this slice are reached by a forwarded access
            next_st.rsp.ack = 1'b0;
            next_st.phase = ECAAS_FWD;
            next_st.fwd.valid = 1'b1;
            next_st.fwd.wr = cfg_req.wr;
            next_st.fwd.idx = tgt;
            next_st.fwd.be = cfg_req.be;
            next_st.fwd.wdata = cfg_req.wdata;
          end
          else
          begin
            next_st.rsp.hit = 1'b0;
          end
        end
      end
      ECAAS_FWD:
      begin
        // No timeout: the forwarded target must always answer
        if (fwd_rsp.ack)
        begin
          next_st.phase = ECAAS_IDLE;
          next_st.rsp.ack = 1'b1;
          next_st.rsp.hit = 1'b1;
          next_st.rsp.rdata = st.fwd.wr ? 32'h0 : (fwd_rsp.rdata & lane_mask(st.fwd.be));
        end
      end
      default:
        next_st.phase = ECAAS_IDLE;
    endcase
    // Hot reset returns the pointer to its default but leaves the sticky flags alone
    if (hot_reset)
    begin
      next_st.ptr_reg = 6'(`ECAAS_PTR_RST >> `ECAAS_PTR_REG_LSB);
      next_st.ptr_ext = 4'(`ECAAS_PTR_RST >> `ECAAS_PTR_EXT_LSB);
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      st.phase <= ECAAS_IDLE;
      st.ptr_reg <= 6'h00;
      st.ptr_ext <= 4'h0;
      st.rsp <= '0;
      st.fwd <= '0;
    end
    else
      st <= next_st;
  end

  assign cfg_rsp = st.rsp;
  assign cfg_busy = st.phase;
  assign fwd_req = st.fwd;
  assign err_flags = flags;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst || hot_reset);

  sequence s_ptr_write;
    take && cfg_req.wr && (cfg_req.addr[11:2] == IDX_PTR);
  endsequence

  sequence s_win_take;
    take && win && !cfg_req.smbus;
  endsequence

  sequence s_fwd_issue;
    s_win_take ##0 (!local_hit && (tgt != IDX_WIN));
  endsequence

  a_ptr_reg_write: assert property (s_ptr_write ##0 cfg_req.be[0] |=> (st.ptr_reg == $past(cfg_req.wdata[7:2])))
    else $error("Pointer register index not written");
  a_ptr_ext_write: assert property (s_ptr_write ##0 cfg_req.be[1] |=> (st.ptr_ext == $past(cfg_req.wdata[11:8])))
    else $error("Pointer extended index not written");
  property p_win_read_flags;
    s_win_take ##0 (!cfg_req.wr && tgt == IDX_FLAGS && cfg_req.be == 4'hf)
      |=> (cfg_rsp.ack && cfg_rsp.rdata == $past(flags));
  endproperty
  a_win_read_flags: assert property (p_win_read_flags)
    else $error("Window read returned wrong flag value");
  property p_win_fwd_write;
    s_fwd_issue ##0 cfg_req.wr
      |=> (fwd_req.valid && fwd_req.wr && fwd_req.wdata == $past(cfg_req.wdata) && fwd_req.idx == $past(tgt));
  endproperty
  a_win_fwd_write: assert property (p_win_fwd_write)
    else $error("Window write not forwarded to pointed register");
  a_win_be_pass: assert property (s_fwd_issue |=> (fwd_req.be == $past(cfg_req.be)) ##1 !fwd_req.valid)
    else $error("Window byte enables altered");
  property p_win_self_zero;
    s_win_take ##0 (tgt == IDX_WIN)
      |=> (cfg_rsp.ack && cfg_rsp.rdata == 32'h0 && $stable(st.ptr_reg) && !fwd_req.valid);
  endproperty
  a_win_self_zero: assert property (p_win_self_zero)
    else $error("Window aimed at itself not zero or not ignored");
  property p_smbus_win_zero;
    (take && win && cfg_req.smbus) |-> !flag_clr_valid
      ##1 (cfg_rsp.ack && cfg_rsp.rdata == 32'h0 && !fwd_req.valid && $stable(st.ptr_ext));
  endproperty
  a_smbus_win_zero: assert property (p_smbus_win_zero)
    else $error("SMBus window access had an effect");
  property p_cap_fixed;
    (take && !win && !cfg_req.wr && tgt == IDX_CAP && cfg_req.be == 4'hf)
      |=> (cfg_rsp.rdata[19:0] == {`ECAAS_CAP_VER, `ECAAS_CAP_CODE});
  endproperty
  a_cap_fixed: assert property (p_cap_fixed)
    else $error("Capability code or version wrong");
  a_fwd_answer: assert property ((st.phase == ECAAS_FWD && fwd_rsp.ack) |=> (cfg_rsp.ack && !cfg_busy))
    else $error("Forwarded answer not returned next cycle");
  a_fwd_wait_busy: assert property ((st.phase == ECAAS_FWD && !fwd_rsp.ack) |=> (cfg_busy && !cfg_rsp.ack))
    else $error("Forwarded access ended without an answer");
  a_fwd_one_pulse: assert property (fwd_req.valid |=> !fwd_req.valid)
    else $error("Forwarded request issued twice");
  property p_fwd_lane_mask;
    (st.phase == ECAAS_FWD && fwd_rsp.ack && !st.fwd.wr) |=> ((cfg_rsp.rdata & ~lane_mask($past(st.fwd.be))) == 32'h0);
  endproperty
  a_fwd_lane_mask: assert property (p_fwd_lane_mask)
    else $error("Forwarded read returned data in a disabled lane");

  // ----------------------------------------
  // Direct reads, read-only header and hot reset
  // ----------------------------------------
  sequence s_direct_read;
    take && !win && !cfg_req.wr && (cfg_req.be == 4'hf);
  endsequence

  property p_ptr_read_back;
    s_direct_read ##0 (tgt == IDX_PTR) |=> (cfg_rsp.rdata == {20'h0, $past(st.ptr_ext), $past(st.ptr_reg), 2'b00});
  endproperty
  a_ptr_read_back: assert property (p_ptr_read_back)
    else $error("Pointer read back wrong or reserved bits set");
  property p_flags_read_live;
    s_direct_read ##0 (tgt == IDX_FLAGS) |=> (cfg_rsp.rdata == $past(flags));
  endproperty
  a_flags_read_live: assert property (p_flags_read_live)
    else $error("Flag register read did not return live flags");
  property p_cap_write_quiet;
    (take && !win && cfg_req.wr && tgt == IDX_CAP) |-> !flag_clr_valid
      ##1 (cfg_rsp.ack && cfg_rsp.hit && !fwd_req.valid && $stable(st.ptr_reg));
  endproperty
  a_cap_write_quiet: assert property (p_cap_write_quiet)
    else $error("Write to read-only header had an effect");

  // Hot reset masks the checks above, so these two carry their own disable
  property p_hot_ptr_clear;
    @(posedge core_clk) disable iff (rst) hot_reset |=> (st.ptr_reg == 6'h00 && st.ptr_ext == 4'h0);
  endproperty
  a_hot_ptr_clear: assert property (p_hot_ptr_clear)
    else $error("Hot reset did not return the pointer to zero");
  property p_hot_flags_keep;
    @(posedge core_clk) disable iff (rst) (hot_reset && !flag_clr_valid && evt == '0) |=> $stable(flags);
  endproperty
  a_hot_flags_keep: assert property (p_hot_flags_keep)
    else $error("Hot reset disturbed the sticky flags");
endmodule
`default_nettype wire

// *** ecaas_cfg_responder.sv ***
// Behavioural model of the configuration space behind the forward port
`timescale 1ns/1ps
`default_nettype none

module ecaas_cfg_responder
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] delay,
  input wire ecaas_pkg::ecaas_fwd_s fwd_req,
  output ecaas_pkg::ecaas_rsp_s fwd_rsp,
  output logic [31:0] wr_count
);
  import ecaas_pkg::*;

  // ----------------------------------------
  // Storage and request tracking
  // ----------------------------------------
  logic [31:0] mem [logic [9:0]];
  logic pend;
  logic [3:0] cnt;
  ecaas_fwd_s held;

  function automatic logic [31:0] peek(input logic [9:0] idx);
    return mem.exists(idx) ? mem[idx] : {22'h2a5, idx};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // Answer after a programmable wait
  // ----------------------------------------
  // Idle read data toggles so a stale value is never mistaken for an answer
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pend <= 1'b0;
      cnt <= 4'h0;
      fwd_rsp <= '0;
      wr_count <= 32'h0;
    end
    else
    begin
      fwd_rsp.ack <= 1'b0;
      fwd_rsp.hit <= 1'b0;
      fwd_rsp.rdata <= ~fwd_rsp.rdata;
      if (fwd_req.valid)
      begin
        pend <= 1'b1;
        cnt <= delay;
        held <= fwd_req;
      end
      else if (pend && cnt != 4'h0)
      begin
        cnt <= cnt - 4'h1;
      end
      else if (pend)
      begin
        pend <= 1'b0;
        fwd_rsp.ack <= 1'b1;
        fwd_rsp.rdata <= peek(held.idx);
        if (held.wr)
        begin
          mem[held.idx] = merge(peek(held.idx), held.wdata, held.be);
          wr_count <= wr_count + 32'h1;
        end
      end
    end
  end
endmodule

`default_nettype wire

// *** ecaas_top_tb.sv ***
// Self-checking testbench of the config access slice
`timescale 1ns/1ps
`default_nettype none
`include "ecaas_regs.svh"

module ecaas_top_tb;
  import ecaas_pkg::*;

  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  localparam logic [11:0] CL = 12'h340;
  logic core_clk;
  logic rst;
  logic hot_reset;
  logic [3:0] delay;
  ecaas_req_s cfg_req;
  ecaas_rsp_s cfg_rsp;
  logic cfg_busy;
  ecaas_fwd_s fwd_req;
  ecaas_rsp_s fwd_rsp;
  ecaas_evt_s evt;
  logic [31:0] err_flags;
  logic [31:0] wr_count;
  logic [31:0] rd;
  logic [31:0] wc;
  logic hit;
  logic busy;
  int error_cnt;
  int total_checks;
  int bits [9] = '{4, 5, 12, 13, 16, 17, 18, 19, 20};

  ecaas_top #(.CHAIN_LINK(CL)) u_ecaas_top (.core_clk(core_clk), .rst(rst), .hot_reset(hot_reset),
    .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .cfg_busy(cfg_busy), .fwd_req(fwd_req), .fwd_rsp(fwd_rsp),
    .evt(evt), .err_flags(err_flags));

  ecaas_cfg_responder u_ecaas_cfg_responder (.core_clk(core_clk), .rst(rst), .delay(delay),
    .fwd_req(fwd_req), .fwd_rsp(fwd_rsp), .wr_count(wr_count));

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One request, valid for one cycle, then a bounded wait for the ack pulse
  task automatic acc(input logic wr, input logic sm, input logic [11:0] a, input logic [3:0] be,
                     input logic [31:0] wd);
    int n;
    @(negedge core_clk);
    cfg_req = '{valid: 1'b1, wr: wr, smbus: sm, addr: a, be: be, wdata: wd};
    @(negedge core_clk);
    cfg_req.valid = 1'b0;
    busy = cfg_busy;
    n = 0;
    while (cfg_rsp.ack !== 1'b1 && n < 100)
    begin
      @(negedge core_clk);
      n++;
    end
    if (n == 100)
    begin
      error_cnt++;
    end
    rd = cfg_rsp.rdata;
    hit = cfg_rsp.hit;
  endtask

  task automatic results();
    $display("Checks %0d, errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
    begin
      $display("RESULT: PASS");
    end
    else
    begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial
  begin
    #(20 * 20000);
    error_cnt++;
    results();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    error_cnt = 0;
    total_checks = 0;
    rst = 1'b1;
    hot_reset = 1'b0;
    delay = 4'h0;
    cfg_req = '0;
    evt = '0;
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    acc(1'b0, 1'b0, `ECAAS_PTR_OFS, 4'hf, 32'h0);
    chk(rd, `ECAAS_PTR_RST);
    acc(1'b0, 1'b0, `ECAAS_FLAGS_OFS, 4'hf, 32'h0);
    chk(rd, `ECAAS_FLAGS_RST);
    acc(1'b1, 1'b0, `ECAAS_PTR_OFS, 4'hf, 32'hffff_ffff);
    acc(1'b0, 1'b0, `ECAAS_PTR_OFS, 4'hf, 32'h0);
    chk(rd, 32'h0000_0ffc);
    for (int i = 0; i < 2; i++)
    begin
      acc(1'b1, 1'b0, `ECAAS_CAP_OFS, 4'hf, 32'hffff_ffff);
      acc(1'b0, 1'b0, `ECAAS_CAP_OFS, 4'hf, 32'h0);
      chk(rd, {CL, 4'h1, 16'h0001});
    end
    acc(1'b0, 1'b0, 12'h010, 4'hf, 32'h0);
    chk({hit, rd[30:0]}, 32'h0);
    // Window path, once with a prompt and once with a slow far side
    for (int d = 0; d < 2; d++)
    begin
      delay = d ? 4'h7 : 4'h0;
      acc(1'b1, 1'b0, `ECAAS_PTR_OFS, 4'hf, 32'h0000_0554);
      chk({31'h0, busy}, 32'h0);
      acc(1'b1, 1'b0, `ECAAS_WIN_OFS, 4'hf, 32'h1122_3344);
      chk({31'h0, busy}, 32'h1);
      acc(1'b1, 1'b0, `ECAAS_WIN_OFS, 4'h5, 32'haabb_ccdd);
      acc(1'b0, 1'b0, `ECAAS_WIN_OFS, 4'hf, 32'h0);
      chk(rd, 32'h11bb_33dd);
      acc(1'b0, 1'b0, `ECAAS_WIN_OFS, 4'h3, 32'h0);
      chk(rd, 32'h0000_33dd);
      chk({22'h0, fwd_req.idx}, 32'h0000_0155);
      chk({31'h0, cfg_busy}, 32'h0);
    end
    wc = wr_count;
    acc(1'b1, 1'b1, `ECAAS_WIN_OFS, 4'hf, 32'h0);
    acc(1'b0, 1'b1, `ECAAS_WIN_OFS, 4'hf, 32'h0);
    chk(rd, 32'h0);
    acc(1'b0, 1'b0, `ECAAS_WIN_OFS, 4'hf, 32'h0);
    chk(rd, 32'h11bb_33dd);
    acc(1'b1, 1'b0, `ECAAS_PTR_OFS, 4'hf, 32'h0000_00fc);
    acc(1'b1, 1'b0, `ECAAS_WIN_OFS, 4'hf, 32'hdead_beef);
    acc(1'b0, 1'b0, `ECAAS_WIN_OFS, 4'hf, 32'h0);
    chk(rd, 32'h0);
    chk(wr_count, wc);
    // Each event sets its own flag, a write of one clears it
    for (int i = 0; i < 9; i++)
    begin
      @(negedge core_clk);
      evt = ecaas_evt_s'(9'h100 >> i);
      @(negedge core_clk);
      evt = '0;
      chk(err_flags, 32'h1 << bits[i]);
      acc(1'b1, 1'b0, `ECAAS_FLAGS_OFS, 4'hf, ~(32'h1 << bits[i]));
      acc(1'b0, 1'b0, `ECAAS_FLAGS_OFS, 4'hf, 32'h0);
      chk(rd, 32'h1 << bits[i]);
      acc(1'b1, 1'b0, `ECAAS_FLAGS_OFS, 4'hf, 32'h1 << bits[i]);
      chk(err_flags, 32'h0);
    end
    @(negedge core_clk);
    evt = '1;
    @(negedge core_clk);
    evt = '0;
    chk(err_flags, `ECAAS_FLAGS_WMASK);
    acc(1'b1, 1'b0, `ECAAS_PTR_OFS, 4'hf, 32'h0000_0104);
    acc(1'b0, 1'b0, `ECAAS_WIN_OFS, 4'hf, 32'h0);
    chk(rd, `ECAAS_FLAGS_WMASK);
    acc(1'b1, 1'b0, `ECAAS_PTR_OFS, 4'hf, 32'h0000_0554);
    @(negedge core_clk);
    hot_reset = 1'b1;
    @(negedge core_clk);
    hot_reset = 1'b0;
    acc(1'b0, 1'b0, `ECAAS_PTR_OFS, 4'hf, 32'h0);
    chk(rd, 32'h0);
    acc(1'b0, 1'b0, `ECAAS_FLAGS_OFS, 4'hf, 32'h0);
    chk(rd, `ECAAS_FLAGS_WMASK);
    acc(1'b1, 1'b0, `ECAAS_FLAGS_OFS, 4'hc, 32'hffff_ffff);
    chk(err_flags, 32'h0000_3030);
    results();
  end
endmodule

`default_nettype wire
